// ==== bench/bol_loader_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module bol_loader_monitor (
    // Clock and resets
    input wire        clk,
    input wire        sys_rst,
    input wire        porRst,
    // Bus
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // Pin and settings
    input wire        rstPinOut,
    input wire        rstPinOe,
    input wire        rstPinPullup,
    input wire        rstPinFilter,
    input wire [2:0]  coreClockDivider,
    input wire        rstPinWakeEnable,
    input wire        chipResetActive,
    input wire        pinWakeRequest,
    input wire        pinWakeOut
);
    // ****
    // Checks
    // ****
    logic [11:0] oeCnt;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst || porRst);
    sequence sTake;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence sAnswer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // Counts how long the pin has been driven low since reset left.
    always_ff @(posedge clk) begin
        if (sys_rst || porRst || !rstPinOe) begin
            oeCnt <= 12'h0;
        end else if (oeCnt != 12'hFFF) begin
            oeCnt <= oeCnt + 12'h1;
        end
    end
    a_ack_answer: assert property (sTake |=> sAnswer)
        else $error("bus request not answered in one cycle");
    a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i)
        && !($past(wb_adr_i) inside {8'h00, 8'h04, 8'h08}) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_drive_low_only: assert property (rstPinOe |-> !rstPinOut)
        else $error("pin driven high");
    a_ded_pull_filt: assert property (rstPinPullup == rstPinFilter)
        else $error("pull-up and filter disagree");
    a_div_legal: assert property (coreClockDivider inside {3'h7, 3'h3, 3'h1, 3'h0})
        else $error("divider outside table");
    a_wake_gated: assert property (!rstPinWakeEnable |-> !pinWakeOut)
        else $error("wake passed while disabled");
    a_wake_follow: assert property (rstPinWakeEnable |-> pinWakeOut == $past(pinWakeRequest))
        else $error("wake request not passed on dedicated pin");
    a_wake_needs_ded: assert property (rstPinWakeEnable |-> rstPinPullup)
        else $error("wake enabled on disabled pin");
    a_pin_low_min: assert property ($fell(rstPinOe) && rstPinPullup |-> oeCnt >= 12'd128)
        else $error("reset pin released early");
    a_chip_rst_hold: assert property (rstPinOe && rstPinPullup |=> chipResetActive)
        else $error("chip reset left while pin low");
endmodule
bind bol_loader bol_loader_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .porRst(porRst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .rstPinPullup(rstPinPullup), .rstPinFilter(rstPinFilter),
    .coreClockDivider(coreClockDivider), .rstPinWakeEnable(rstPinWakeEnable),
    .chipResetActive(chipResetActive), .pinWakeRequest(pinWakeRequest),
    .pinWakeOut(pinWakeOut));
`default_nettype wire

// ==== bench/bol_loader_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module bol_loader_tb;
    // ****
    // Bench state
    // ****
    logic clk = 0, sys_rst = 1, porRst = 1, vllsWake = 0, cyc = 0, stb = 0, we = 0;
    logic progEn = 0, progErase = 0, wakeReq = 0, expPin = 1;
    logic [7:0] adr = 0, progByte = 0, expB = 8'hFF, b;
    logic [3:0] sel = 4'h1;
    logic [31:0] wdat = 0, rd;
    wire logic [31:0] datO;
    wire logic [7:0] nvByte;
    wire logic [2:0] div;
    wire logic ack, pinIn, pinOut, pinOe, pull, filt, fastA, wakeEn, chipRst, wakeOut, nvEr;
    int n_mismatch = 0, checks_done = 0, cycN = 0, t, i;
    int divTab[4] = '{7, 3, 1, 0};
    integer seed = 32'h2a383660;
    always #25 clk = ~clk;
    bol_loader DUT (.clk(clk), .sys_rst(sys_rst), .porRst(porRst), .vllsWake(vllsWake),
        .nvOptionByte(nvByte), .nvErased(nvEr), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(datO),
        .wb_ack_o(ack), .rstPinIn(pinIn), .rstPinOut(pinOut), .rstPinOe(pinOe),
        .rstPinPullup(pull), .rstPinFilter(filt), .coreClockDivider(div),
        .fastInitActive(fastA), .rstPinWakeEnable(wakeEn), .chipResetActive(chipRst),
        .pinWakeRequest(wakeReq), .pinWakeOut(wakeOut));
    bol_nvm_model nvm (.clk(clk), .progEn(progEn), .progErase(progErase),
        .progByte(progByte), .nvOptionByte(nvByte), .nvErased(nvEr),
        .rstPinOe(pinOe), .rstPinOut(pinOut), .rstPinIn(pinIn));
    // ****
    // Tasks
    // ****
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chkMin(input string nm, input int lo, input int g);
        checks_done++;
        if (g < lo) begin
            n_mismatch++;
            $display("MISMATCH %s exp >= %0d got %0d", nm, lo, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'($random(seed)) | 4'h1;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rd = datO;
        cyc <= 0;
        stb <= 0;
        @(negedge clk);
    endtask
    task automatic rst(input int k);
        @(posedge clk);
        porRst <= (k == 0);
        sys_rst <= (k != 2);
        vllsWake <= (k == 2);
        repeat (5) @(posedge clk);
        porRst <= 0;
        sys_rst <= 0;
        vllsWake <= 0;
        if (k == 0) expPin = expB[3];
        t = 0;
        @(posedge clk);
        while (chipRst !== 1'b0) begin
            @(posedge clk);
            t++;
        end
    endtask
    task automatic prog(input logic [7:0] v, input logic er);
        @(posedge clk);
        progEn <= !er;
        progErase <= er;
        progByte <= v;
        sys_rst <= er;
        @(posedge clk);
        progEn <= 0;
        progErase <= 0;
        sys_rst <= 0;
    endtask
    task automatic chkAll;
        bus(0, 8'h00, 0);
        chk("option", {24'h0, expB}, rd);
        chk("divider", divTab[{expB[4], expB[0]}], div);
        chk("fastInit", expB[5], fastA);
        chk("pullup", expPin, pull);
        chk("wakeEn", expPin, wakeEn);
        bus(0, 8'h04, 0);
        chk("statusFast", expB[5], rd[2]);
        chk("statusPin", expPin, rd[1]);
        chk("statusDone", 1, rd[0]);
    endtask
    always @(posedge clk) begin
        cycN++;
        if (cycN == 30000) begin
            n_mismatch++;
            summarize;
        end
    end
    // ****
    // Scenarios
    // ****
    initial begin
        rst(0);
        chkAll;
        bus(1, 8'h00, $random(seed));
        bus(1, 8'h04, $random(seed));
        chkAll;
        bus(0, 8'h0C, 0);
        chk("unmapped", 0, rd);
        $display("test 1 done");
        for (i = 0; i < 4; i++) begin
            b = $random(seed);
            b[5] = (i != 0);
            b[4] = i[1];
            b[3] = 1'b1;
            b[0] = i[0];
            prog(b, 0);
            expB = b;
            rst(i % 3);
            chkAll;
            chkMin("pinLow", 128, t);
            if (i == 0) chkMin("slowTime", 512, t);
            else chkMin("fastTime", t, 300);
        end
        $display("test 2 done");
        prog(8'h39, 0);
        bus(0, 8'h00, 0);
        chk("stale", {24'h0, expB}, rd);
        expB = 8'h39;
        rst(1);
        chkAll;
        $display("test 3 done");
        prog(8'h31, 0);
        expB = 8'h31;
        rst(1);
        chkAll;
        rst(0);
        chkAll;
        chk("filter", 0, filt);
        @(posedge clk);
        wakeReq <= 1;
        repeat (3) @(posedge clk);
        chk("wakeOut", 0, wakeOut);
        bus(1, 8'h08, 2);
        chk("gpioOe", 1, pinOe);
        bus(1, 8'h08, 3);
        chk("gpioOe", 0, pinOe);
        rst(2);
        chkAll;
        prog(8'h00, 1);
        expB = 8'hFF;
        rst(0);
        chkAll;
        repeat (3) @(posedge clk);
        chk("wakeOut", 1, wakeOut);
        $display("test 4 done");
        summarize;
    end
endmodule
`default_nettype wire

// ==== bench/bol_nvm_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module bol_nvm_model (
    // Clock
    input wire         clk,
    // Programming path
    input wire         progEn,
    input wire         progErase,
    input wire [7:0]   progByte,
    // Option byte
    output logic [7:0] nvOptionByte,
    output logic       nvErased,
    // Pin
    input wire         rstPinOe,
    input wire         rstPinOut,
    output logic       rstPinIn
);
    // ****
    // Storage and pin
    // ****
    initial begin
        nvOptionByte = 8'hFF;
        nvErased = 1'b1;
    end
    always @(posedge clk) begin
        if (progErase) begin
            nvOptionByte <= 8'hFF;
            nvErased <= 1'b1;
        end else if (progEn) begin
            nvOptionByte <= progByte;
            nvErased <= 1'b0;
        end
    end
    // The board pull-up lifts the pin whenever nobody sinks it.
    assign rstPinIn = (rstPinOe && !rstPinOut) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ==== inc/bol_regs.vh ====
`ifndef BOL_REGS_VH
`define BOL_REGS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define BOL_ADDR_OPTION   8'h00
`define BOL_ADDR_STATUS   8'h04
`define BOL_ADDR_PINCTRL  8'h08

// ****************************************************************
// Option byte fields
// ****************************************************************
`define BOL_ERASED_BYTE   8'hFF
`define BOL_BIT_FASTINIT  5
`define BOL_BIT_RSTPIN    3
`define BOL_BIT_DIVHI     4
`define BOL_BIT_DIVLO     0

// ****************************************************************
// Divider reset values
// ****************************************************************
`define BOL_DIV_SEL00     3'h7
`define BOL_DIV_SEL01     3'h3
`define BOL_DIV_SEL10     3'h1
`define BOL_DIV_SEL11     3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define BOL_PIN_LOW_MIN   8'h80
`define BOL_INIT_FAST     8'h10

// ****************************************************************
// Status and pin control fields
// ****************************************************************
`define BOL_ST_DONE       0
`define BOL_ST_PINRST     1
`define BOL_ST_FASTINIT   2
`define BOL_PC_OUT        0
`define BOL_PC_OE         1

`endif

// ==== logic/bol_init_timer.v ====
`timescale 1ns/1ns
`default_nettype none
`include "bol_regs.vh"

module bol_init_timer (
    // Clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // Control
    input  wire       start,
    input  wire       fastInit,
    input  wire [2:0] coreDiv,
    // Status
    output reg        done
);

    reg [11:0] count_reg;
    reg        busy_reg;

    // Slow initialization stretches with the divider value.
    function [11:0] initLength;
        input       fast;
        input [2:0] div;
        begin
            if (fast) begin
                initLength = {4'h0, `BOL_INIT_FAST};
            end else begin
                initLength = {4'h0, `BOL_INIT_FAST} * ({9'h000, div} + 12'h001) * 12'h004;
            end
        end
    endfunction

    always @(posedge clk) begin
        if (sys_rst) begin
            count_reg <= 12'h000;
            busy_reg  <= 1'b0;
            done      <= 1'b0;
        end else if (start) begin
            // RL5 slow init
            // RL6 fast init
            count_reg <= initLength(fastInit, coreDiv);
            busy_reg  <= 1'b1;
            done      <= 1'b0;
        end else if (busy_reg) begin
            if (count_reg == 12'h001) begin
                busy_reg <= 1'b0;
                done     <= 1'b1;
            end
            count_reg <= count_reg - 12'h001;
        end
    end

endmodule
`default_nettype wire

// ==== logic/bol_loader.v ====
// Overview of operation
// RL1 - Software reads the option byte copy only; writes change nothing.
// RL2 - An erased option byte reads as all ones.
// RL3 - New option byte values apply only at the next reset load.
// RL4 - Bit 5 selects flash initialization speed on every reset kind.
// RL5 - Bit 5 low gives slow initialization scaled by the divider choice.
// RL6 - Bit 5 high gives fast initialization.
// RL7 - Bit 3 low disables the reset pin function after power-on reset.
// RL8 - With pin disabled, it may be driven low briefly during power-on.
// RL9 - Disabled reset pin used as output drives pseudo open-drain only.
// RL10 - Bit 3 is kept through system resets; reloaded only at power-on.
// RL11 - Disabled reset pin is not accepted as a wake-up source.
// RL12 - Debugger sets mass erase and reset request together when locked.
// RL13 - Bit 3 high dedicates pin to reset with pull-up and filter.
// RL14 - The option byte is loaded early, before divider and speed apply.
// RL15 - Divider select 00,01,10,11 gives core divider 7,3,1,0.
// RL16 - Reset pin held low at least 128 cycles and until init ends.
// RL17 - Bits 7 and 6 have no effect and read back as loaded.
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "bol_regs.vh"

module bol_loader (
    // Clock and resets
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        porRst,
    input  wire        vllsWake,
    // Non-volatile option byte
    input  wire [7:0]  nvOptionByte,
    input  wire        nvErased,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Reset pin
    input  wire        rstPinIn,
    output reg         rstPinOut,
    output reg         rstPinOe,
    output reg         rstPinPullup,
    output reg         rstPinFilter,
    // Applied settings
    output reg  [2:0]  coreClockDivider,
    output reg         fastInitActive,
    output reg         rstPinWakeEnable,
    output reg         chipResetActive,
    input  wire        pinWakeRequest,
    output reg         pinWakeOut
);

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    localparam ST_LOAD  = 2'd0;
    localparam ST_APPLY = 2'd1;
    localparam ST_INIT  = 2'd2;
    localparam ST_RUN   = 2'd3;

    reg [1:0]  state_reg;
    reg [7:0]  bootOption_reg;
    reg        pinFunc_reg;
    reg        pinFuncValid_reg;
    reg [7:0]  lowCount_reg;
    reg        initStart_reg;
    reg        gpioOut_reg;
    reg        gpioOe_reg;
    wire       initDone;
    wire [7:0] loadValue;
    wire       pinDedicated;

    // RL15 divider decode
    function [2:0] divFromSelect;
        input [1:0] sel;
        begin
            if (sel == 2'b00) begin
                divFromSelect = `BOL_DIV_SEL00;
            end else if (sel == 2'b01) begin
                divFromSelect = `BOL_DIV_SEL01;
            end else if (sel == 2'b10) begin
                divFromSelect = `BOL_DIV_SEL10;
            end else begin
                divFromSelect = `BOL_DIV_SEL11;
            end
        end
    endfunction

    // RL2 erased reads ones
    assign loadValue = nvErased ? `BOL_ERASED_BYTE : nvOptionByte;

    // RL10 pin select retained
    assign pinDedicated = pinFuncValid_reg ? pinFunc_reg : 1'b1;

    bol_init_timer uInitTimer (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .start    (initStart_reg),
        .fastInit (bootOption_reg[`BOL_BIT_FASTINIT]),
        .coreDiv  (coreClockDivider),
        .done     (initDone)
    );

    // ****************************************************************
    // Power-on only state
    // ****************************************************************
    always @(posedge clk) begin
        if (porRst) begin
            pinFuncValid_reg <= 1'b0;
            pinFunc_reg      <= 1'b1;
        end else if (state_reg == ST_LOAD && !pinFuncValid_reg) begin
            // RL10 power-on reload
            pinFunc_reg      <= loadValue[`BOL_BIT_RSTPIN];
            pinFuncValid_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // Reset sequencer
    // ****************************************************************
    always @(posedge clk) begin
        if (sys_rst || porRst || vllsWake) begin
            state_reg        <= ST_LOAD;
            bootOption_reg   <= `BOL_ERASED_BYTE;
            coreClockDivider <= `BOL_DIV_SEL00;
            fastInitActive   <= 1'b1;
            lowCount_reg     <= 8'h00;
            initStart_reg    <= 1'b0;
            chipResetActive  <= 1'b1;
        end else begin
            initStart_reg <= 1'b0;
            if (lowCount_reg != `BOL_PIN_LOW_MIN) begin
                lowCount_reg <= lowCount_reg + 8'h01;
            end
            case (state_reg)
                ST_LOAD: begin
                    // RL3 reload at reset
                    // RL14 load early
                    // RL17 reserved as loaded
                    bootOption_reg <= loadValue;
                    state_reg      <= ST_APPLY;
                end
                ST_APPLY: begin
                    // RL15 apply divider
                    coreClockDivider <= divFromSelect({bootOption_reg[`BOL_BIT_DIVHI],
                                                       bootOption_reg[`BOL_BIT_DIVLO]});
                    // RL4 speed select
                    fastInitActive   <= bootOption_reg[`BOL_BIT_FASTINIT];
                    initStart_reg    <= 1'b1;
                    state_reg        <= ST_INIT;
                end
                ST_INIT: begin
                    // RL16 low count and init
                    if (initDone && lowCount_reg == `BOL_PIN_LOW_MIN) begin
                        state_reg <= ST_RUN;
                    end
                end
                default: begin
                    // A dedicated pin held low externally delays release.
                    chipResetActive <= pinDedicated ? !rstPinIn : 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Reset pin drive
    // ****************************************************************
    always @(posedge clk) begin
        if (sys_rst || porRst) begin
            rstPinOut        <= 1'b0;
            rstPinOe         <= 1'b1;
            rstPinPullup     <= 1'b1;
            rstPinFilter     <= 1'b1;
            rstPinWakeEnable <= 1'b0;
            pinWakeOut       <= 1'b0;
        end else if (pinDedicated) begin
            // RL13 dedicated reset pin
            rstPinPullup     <= 1'b1;
            rstPinFilter     <= 1'b1;
            rstPinOut        <= 1'b0;
            rstPinOe         <= (state_reg != ST_RUN);
            rstPinWakeEnable <= 1'b1;
            pinWakeOut       <= pinWakeRequest;
        end else begin
            // RL7 pin function off
            // RL8 low until settled
            // RL9 pseudo open drain
            rstPinPullup     <= 1'b0;
            rstPinFilter     <= 1'b0;
            rstPinOut        <= 1'b0;
            rstPinOe         <= (state_reg == ST_LOAD) || (gpioOe_reg && !gpioOut_reg);
            // RL11 no wake source
            rstPinWakeEnable <= 1'b0;
            pinWakeOut       <= 1'b0;
        end
    end

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h00000000;
            gpioOut_reg <= 1'b1;
            gpioOe_reg  <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_dat_o <= 32'h00000000;
                if (wb_adr_i == `BOL_ADDR_OPTION) begin
                    // RL1 read-only copy
                    wb_dat_o <= {24'h000000, bootOption_reg};
                end else if (wb_adr_i == `BOL_ADDR_STATUS) begin
                    wb_dat_o <= {29'h0000000, fastInitActive, pinDedicated,
                                 state_reg == ST_RUN};
                end else if (wb_adr_i == `BOL_ADDR_PINCTRL) begin
                    wb_dat_o <= {30'h0000000, gpioOe_reg, gpioOut_reg};
                    if (wb_we_i && wb_sel_i[0]) begin
                        gpioOut_reg <= wb_dat_i[`BOL_PC_OUT];
                        gpioOe_reg  <= wb_dat_i[`BOL_PC_OE];
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire
